// ===== core/buck_peak_current_regs.sv
// Purpose: Register bank for peak current code, range and low-output pre-driver enables
// Assumes: Serial frame decoding is outside; it presents one access per strobe
// Notes:   Read data registered one cycle after the read strobe
//          Register 3 reads back the written ranges; the range outputs show the applied ones
//          Fail-safe clears codes and ranges only; enables and topology keep their value
//
// Contract
// [R01] Register 0 always reads zero whatever was written.
// [R02] Writing all ones to register 0 in daisy-chain mode switches the port to star mode.
// [R03] Register 1 holds channel one's 9-bit code in bits 8:0, reset zero, bit 9 reads zero.
// [R04] Register 2 holds channel two's 9-bit code in bits 8:0, reset zero, bit 9 reads zero.
// [R05] The peak target rises linearly with the code; base and step double per range.
// [R06] Register 3 holds channel one's range in bits 5:3 and channel two's in bits 2:0.
// [R07] Channel two's range uses the same 000..100 encoding as channel one.
// [R08] A new range takes effect only when that channel's code is next written.
// [R09] Bit 7 of register 3 enables channel one's low-side pre-driver at low output voltage.
// [R10] Bit 6 of register 3 enables channel two's low-side pre-driver at low output voltage.
// [R11] Fail-safe fields are forced to zero on entry to fail-safe operation and at reset.
module buck_peak_current_regs
  import peak_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                              clk_sys_i,
  input  wire logic                              reset_i,
  // Fail-safe operation entry level
  input  wire logic                              fail_safe_operation_i,
  // Register access port from the serial front end
  input  wire logic                              reg_wr_i,
  input  wire logic                              reg_rd_i,
  input  wire logic [peak_regs_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [peak_regs_pkg::DATA_W-1:0]  reg_wdata_i,
  output logic      [peak_regs_pkg::DATA_W-1:0]  reg_rdata_o,
  output logic                                   reg_rvalid_o,
  // Serial topology
  output logic                                   star_mode_o,
  // Regulator settings
  output logic      [peak_regs_pkg::CODE_W-1:0]  ch1_peak_current_code_o,
  output logic      [peak_regs_pkg::RANGE_W-1:0] ch1_current_range_sel_o,
  output logic      [peak_regs_pkg::CODE_W-1:0]  ch2_peak_current_code_o,
  output logic      [peak_regs_pkg::RANGE_W-1:0] ch2_current_range_sel_o,
  output logic                                   ch1_lowside_lowvout_en_o,
  output logic                                   ch2_lowside_lowvout_en_o
);
  import peak_regs_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic sel_nop   = (reg_addr_i == ADDR_NOP);
  wire logic sel_ch1   = (reg_addr_i == ADDR_CH1_PEAK);
  wire logic sel_ch2   = (reg_addr_i == ADDR_CH2_PEAK);
  wire logic sel_range = (reg_addr_i == ADDR_RANGE);
  wire logic wr_nop    = reg_wr_i && sel_nop;
  wire logic wr_ch1    = reg_wr_i && sel_ch1; // [R03]
  wire logic wr_ch2    = reg_wr_i && sel_ch2; // [R04]
  wire logic wr_range  = reg_wr_i && sel_range;
  // Only the complete all-ones word counts; any other word written here is dropped
  wire logic star_key  = wr_nop && (reg_wdata_i == STAR_KEY);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic                 star_reg;
  logic                 ls1_reg;
  logic                 ls2_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic                 rvalid_reg;
  logic [RANGE_W-1:0]   rng1_stored;
  logic [RANGE_W-1:0]   rng2_stored;
  logic [DATA_W-1:0]    rdata_next;

  // Topology is not a fail-safe field, so only reset returns it to daisy chain
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      star_reg <= 1'b0;
    end else if (star_key && !star_reg) begin
      star_reg <= 1'b1; // [R02]
    end
  end

  // Pre-driver enables are not fail-safe reloaded and keep their value in fail-safe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ls1_reg <= 1'b0;
      ls2_reg <= 1'b0;
    end else if (wr_range) begin
      ls1_reg <= reg_wdata_i[LS1_LOWV_BIT]; // [R09]
      ls2_reg <= reg_wdata_i[LS2_LOWV_BIT]; // [R10]
    end
  end

  // The analog loop scales the code linearly per applied range
  range_apply_cell u_ch1 ( // [R05]
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .fail_safe_i    (fail_safe_operation_i),
    .range_we_i     (wr_range),
    .range_wdata_i  (reg_wdata_i[RNG_CH1_MSB:RNG_CH1_LSB]),
    .code_we_i      (wr_ch1),
    .code_wdata_i   (reg_wdata_i[CODE_W-1:0]),
    .range_stored_o (rng1_stored),
    .code_o         (ch1_peak_current_code_o),
    .range_active_o (ch1_current_range_sel_o)
  );

  range_apply_cell u_ch2 (
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .fail_safe_i    (fail_safe_operation_i),
    .range_we_i     (wr_range),
    .range_wdata_i  (reg_wdata_i[RNG_CH2_MSB:RNG_CH2_LSB]), // [R07]
    .code_we_i      (wr_ch2),
    .code_wdata_i   (reg_wdata_i[CODE_W-1:0]),
    .range_stored_o (rng2_stored),
    .code_o         (ch2_peak_current_code_o),
    .range_active_o (ch2_current_range_sel_o)
  );

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Unmapped addresses read zero as well
  assign rdata_next = sel_nop   ? READ_ZERO : // [R01]
                      sel_ch1   ? {1'b0, ch1_peak_current_code_o} : // [R03]
                      sel_ch2   ? {1'b0, ch2_peak_current_code_o} : // [R04]
                      sel_range ? {2'b00, ls1_reg, ls2_reg, rng1_stored, rng2_stored} : // [R06]
                      READ_ZERO;

  // Read data holds until the next read, so the front end may shift it out late
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_reg  <= READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_o              = rdata_reg;
  assign reg_rvalid_o             = rvalid_reg;
  assign star_mode_o              = star_reg;
  assign ch1_lowside_lowvout_en_o = ls1_reg;
  assign ch2_lowside_lowvout_en_o = ls2_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  nop_reads_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R01]
    reg_rd_i && sel_nop |=> reg_rvalid_o && reg_rdata_o == 10'h000) else $error("nop read not zero");
  star_switch_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R02]
    star_key |=> star_mode_o) else $error("all-ones nop did not select star");
  star_hold_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R02]
    !star_key && !star_mode_o |=> !star_mode_o) else $error("star mode without key");
  ch1_bit9_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R03]
    reg_rd_i && sel_ch1 |=> reg_rdata_o[9] == 1'b0 && reg_rdata_o[8:0] == $past(ch1_peak_current_code_o))
    else $error("ch1 code readback wrong");
  ch2_code_write_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R04]
    wr_ch2 |=> ch2_peak_current_code_o == $past(reg_wdata_i[8:0])) else $error("ch2 code not written");
  range_fields_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R06]
    wr_range ##1 !wr_range ##1 (reg_rd_i && sel_range) |=> reg_rdata_o[5:0] == $past(reg_wdata_i[5:0], 3))
    else $error("range fields readback wrong");
  ls_enables_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R09]
    wr_range |=> ch1_lowside_lowvout_en_o == $past(reg_wdata_i[7])
    && ch2_lowside_lowvout_en_o == $past(reg_wdata_i[6])) else $error("pre-driver enable wrong"); // [R10]
  fail_safe_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R11]
    fail_safe_operation_i |=> ch1_peak_current_code_o == 9'h000 && ch2_current_range_sel_o == 3'h0)
    else $error("fail-safe fields not cleared");
  fail_safe_rest_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R11]
    fail_safe_operation_i |=> ch2_peak_current_code_o == 9'h000 && ch1_current_range_sel_o == 3'h0
    && rng1_stored == RANGE_RESET && rng2_stored == RANGE_RESET) else $error("fail-safe ranges not cleared");

  // ----------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------
  // Valid is a one-cycle pulse exactly one edge after the strobe
  rvalid_follows_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R01]
    reg_rvalid_o == $past(reg_rd_i)) else $error("read valid not one cycle after strobe");
  rdata_hold_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R01]
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data changed without a read");
  unmapped_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R01]
    reg_rd_i && !(sel_nop || sel_ch1 || sel_ch2 || sel_range) |=> reg_rdata_o == READ_ZERO)
    else $error("unmapped read not zero");
  ch2_bit9_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R04]
    reg_rd_i && sel_ch2 |=> reg_rdata_o[9] == 1'b0 && reg_rdata_o[8:0] == $past(ch2_peak_current_code_o))
    else $error("ch2 code readback wrong");
  range_upper_zero_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R06]
    reg_rd_i && sel_range |=> reg_rdata_o[9:8] == 2'b00) else $error("range register upper bits not zero");

  // ----------------------------------------------------------------
  // Setting checks
  // ----------------------------------------------------------------
  ch1_code_write_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R03]
    wr_ch1 |=> ch1_peak_current_code_o == $past(reg_wdata_i[8:0])) else $error("ch1 code not written");
  // One port means a range write and a code write never share a cycle: the stored range is applied
  ch1_range_apply_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R08]
    wr_ch1 |=> ch1_current_range_sel_o == $past(rng1_stored)) else $error("ch1 range not applied with code");
  ch2_range_apply_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R08]
    wr_ch2 |=> ch2_current_range_sel_o == $past(rng2_stored)) else $error("ch2 range not applied with code");
  range_stored_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_operation_i) // [R06]
    wr_range |=> rng1_stored == $past(reg_wdata_i[5:3]) && rng2_stored == $past(reg_wdata_i[2:0])) // [R07]
    else $error("range fields not stored");
  ch1_code_hold_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R08]
    !wr_ch1 && !fail_safe_operation_i |=> $stable(ch1_peak_current_code_o))
    else $error("ch1 code changed without a write");
  ch2_code_hold_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R08]
    !wr_ch2 && !fail_safe_operation_i |=> $stable(ch2_peak_current_code_o))
    else $error("ch2 code changed without a write");
  star_sticky_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R02]
    star_mode_o |=> star_mode_o) else $error("star mode dropped without reset");
  // Enables are not fail-safe fields, so they must hold through fail-safe as well
  ls_hold_a : assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R09] [R10] [R11]
    !wr_range |=> $stable(ch1_lowside_lowvout_en_o) && $stable(ch2_lowside_lowvout_en_o))
    else $error("pre-driver enable changed without a write");

  cover_star : cover property (@(posedge clk_sys_i) star_key ##1 star_mode_o);
  cover_range_read : cover property (@(posedge clk_sys_i) wr_range ##2 (reg_rd_i && sel_range));
  cover_ch2_applied : cover property (@(posedge clk_sys_i) wr_ch2 ##1 ch2_current_range_sel_o == RANGE_MAX);
  cover_fail_safe : cover property (@(posedge clk_sys_i) fail_safe_operation_i ##1 !fail_safe_operation_i);
endmodule

// ===== include/peak_regs_pkg.sv
// Purpose: Constants for the two-channel peak current register bank
// Assumes: 10-bit register words, 5-bit register index
// Notes:   Shared by the bank and its field-update cell
package peak_regs_pkg;
  localparam int unsigned DATA_W         = 10;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned CODE_W         = 9;
  localparam int unsigned RANGE_W        = 3;

  localparam logic [4:0] ADDR_NOP        = 5'h00;
  localparam logic [4:0] ADDR_CH1_PEAK   = 5'h01;
  localparam logic [4:0] ADDR_CH2_PEAK   = 5'h02;
  localparam logic [4:0] ADDR_RANGE      = 5'h03;

  localparam int unsigned RNG_CH1_MSB    = 5;
  localparam int unsigned RNG_CH1_LSB    = 3;
  localparam int unsigned RNG_CH2_MSB    = 2;
  localparam int unsigned RNG_CH2_LSB    = 0;
  localparam int unsigned LS1_LOWV_BIT   = 7;
  localparam int unsigned LS2_LOWV_BIT   = 6;

  localparam logic [9:0] STAR_KEY        = 10'h3ff;
  localparam logic [8:0] CODE_RESET      = 9'h000;
  localparam logic [2:0] RANGE_RESET     = 3'h0;
  localparam logic [2:0] RANGE_MAX       = 3'h4;
  localparam logic [9:0] READ_ZERO       = 10'h000;
endpackage

// ===== core/range_apply_cell.sv
// Purpose: Holds one channel's code and range and applies them together
// Assumes: Write strobes are single-cycle and synchronous to clk_sys_i
// Notes:   Range takes effect only with the next code write
module range_apply_cell
  import peak_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  input  wire logic                          fail_safe_i,
  // Register side
  input  wire logic                          range_we_i,
  input  wire logic [peak_regs_pkg::RANGE_W-1:0] range_wdata_i,
  input  wire logic                          code_we_i,
  input  wire logic [peak_regs_pkg::CODE_W-1:0]  code_wdata_i,
  // Stored and applied values
  output logic      [peak_regs_pkg::RANGE_W-1:0] range_stored_o,
  output logic      [peak_regs_pkg::CODE_W-1:0]  code_o,
  output logic      [peak_regs_pkg::RANGE_W-1:0] range_active_o
);
  import peak_regs_pkg::*;

  logic [RANGE_W-1:0] range_reg;
  logic [RANGE_W-1:0] active_reg;
  logic [CODE_W-1:0]  code_reg;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || fail_safe_i) begin // [R11]
      range_reg  <= RANGE_RESET;
      active_reg <= RANGE_RESET;
      code_reg   <= CODE_RESET;
    end else begin
      if (range_we_i) begin
        range_reg <= range_wdata_i; // [R06] [R07]
      end
      if (code_we_i) begin
        code_reg   <= code_wdata_i;
        // A same-cycle range write is applied too, so code and range stay paired
        active_reg <= range_we_i ? range_wdata_i : range_reg; // [R08]
      end
    end
  end

  assign range_stored_o = range_reg;
  assign code_o         = code_reg;
  assign range_active_o = active_reg;

  apply_only_on_code_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_i) // [R08]
    !code_we_i |=> $stable(range_active_o)) else $error("range applied without code write");
  apply_takes_range_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_i) // [R08]
    code_we_i && !range_we_i |=> range_active_o == $past(range_stored_o))
    else $error("code write did not apply stored range");
  code_capture_a : assert property (@(posedge clk_sys_i) disable iff (reset_i || fail_safe_i) // [R03]
    code_we_i |=> code_o == $past(code_wdata_i)) else $error("code not captured");
  cover_range_then_code : cover property (@(posedge clk_sys_i) range_we_i ##[1:4] code_we_i);
endmodule

// ===== test/spi_host_model.sv
// Purpose: Serial host model driving the register access port
// Assumes: Requests launched by non-blocking assignment at the rising edge
// Notes:   Released address and data are inverted so a stale value never passes for a live one
module spi_host_model
  import peak_regs_pkg::*;
(
  // Clock
  input  wire logic                             clk_sys_i,
  // Register access port
  output logic                                  reg_wr_o,
  output logic                                  reg_rd_o,
  output logic      [peak_regs_pkg::ADDR_W-1:0] reg_addr_o,
  output logic      [peak_regs_pkg::DATA_W-1:0] reg_wdata_o,
  input  wire logic [peak_regs_pkg::DATA_W-1:0] reg_rdata_i,
  input  wire logic                             reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = '0;
    reg_wdata_o = '0;
  end

  // One access; read data counts only when the valid pulse shows exactly one cycle later
  task automatic access(input logic w, input logic [4:0] a, input logic [9:0] d, output logic [9:0] q);
    @(posedge clk_sys_i);
    reg_wr_o <= w;
    reg_rd_o <= ~w;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
    q = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 'x;
  endtask
endmodule

// ===== test/buck_peak_current_regs_bench.sv
// Purpose: Self-checking bench for the peak current register bank
// Assumes: Host model performs every register access
// Notes:   Analog target scaling is not visible at these ports
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module buck_peak_current_regs_bench import peak_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fail_safe = 1'b0;
  logic wr, rd, rvalid, star, l1, l2;
  logic [4:0] addr;
  logic [9:0] wdata, rdata, q, d;
  logic [8:0] c1, c2;
  logic [2:0] r1, r2, p1, p2;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  buck_peak_current_regs buck_peak_current_regs_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .fail_safe_operation_i(fail_safe), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .star_mode_o(star),
    .ch1_peak_current_code_o(c1), .ch1_current_range_sel_o(r1), .ch2_peak_current_code_o(c2),
    .ch2_current_range_sel_o(r2), .ch1_lowside_lowvout_en_o(l1), .ch2_lowside_lowvout_en_o(l2));
  spi_host_model spi_host_model_inst (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  // --------------------------------------------------------------------------
  // Access helpers and verdict
  // --------------------------------------------------------------------------
  task automatic wr_reg(input logic [4:0] a, input logic [9:0] v);
    spi_host_model_inst.access(1'b1, a, v, q);
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [9:0] e);
    spi_host_model_inst.access(1'b0, a, 10'h000, q);
    `CHK("read data", e, q)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // A hang gives up long after the fewer than one hundred cycles the scenarios need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    `CHK("outputs", 27'h0, {star, c1, r1, c2, r2, l1, l2})
    chk_rd(ADDR_CH1_PEAK, 10'h000);
    chk_rd(ADDR_CH2_PEAK, 10'h000);
    chk_rd(ADDR_RANGE, 10'h000);
  endtask
  task automatic t_nop();
    wr_reg(ADDR_NOP, 10'h155);
    chk_rd(ADDR_NOP, 10'h000);
    `CHK("star", 1'b0, star)
    wr_reg(ADDR_NOP, 10'h3ff);
    `CHK("star", 1'b1, star)
    chk_rd(ADDR_NOP, 10'h000);
    chk_rd(5'h1f, 10'h000);
  endtask
  task automatic t_codes();
    wr_reg(ADDR_CH1_PEAK, 10'h3ff);
    `CHK("code1", 9'h1ff, c1)
    chk_rd(ADDR_CH1_PEAK, 10'h1ff);
    wr_reg(ADDR_CH2_PEAK, 10'h2aa);
    `CHK("code2", 9'h0aa, c2)
    chk_rd(ADDR_CH2_PEAK, 10'h0aa);
  endtask
  // Range first, code second, as the host must order it
  task automatic t_range();
    p1 = 3'h0;
    p2 = 3'h0;
    for (int r = 0; r < 5; r++) begin
      d = {2'b11, r[0], ~r[0], r[2:0], 3'(4 - r)};
      wr_reg(ADDR_RANGE, d);
      `CHK("lowside", {r[0], ~r[0]}, {l1, l2})
      `CHK("range held", {p1, p2}, {r1, r2})
      chk_rd(ADDR_RANGE, {2'b00, d[7:0]});
      wr_reg(ADDR_CH1_PEAK, 10'(r * 3));
      `CHK("range1", {r[2:0], p2}, {r1, r2})
      wr_reg(ADDR_CH2_PEAK, 10'(r * 5));
      `CHK("range2", 3'(4 - r), r2)
      p1 = r[2:0];
      p2 = 3'(4 - r);
    end
  endtask
  task automatic t_fail_safe();
    @(posedge clk_sys_i);
    fail_safe <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("safe", 26'h1, {c1, r1, c2, r2, l1, l2})
    wr_reg(ADDR_CH1_PEAK, 10'h0ff);
    `CHK("safe code", 9'h000, c1)
    @(posedge clk_sys_i);
    fail_safe <= 1'b0;
    chk_rd(ADDR_CH1_PEAK, 10'h000);
    chk_rd(ADDR_RANGE, 10'h040);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    t_reset();
    t_nop();
    t_codes();
    t_range();
    t_fail_safe();
    print_verdict();
  end
endmodule
